// >>> design/timer16_core.sv
// 16-bit timer core with byte access through a shared high-byte holding register.
`timescale 1ns/1ns
module timer16_core import timer16_pkg::*; #(
   parameter bit HAS_EXT_PIN = 1'b1        // Second instance sets this to zero
) (
   input wire logic clock,                  // System clock, 250 MHz
   input wire logic rst,                    // Asynchronous reset, active high
   input wire logic power_gate,             // Counting and capture stopped while high
   input wire timer_ctrl_s ctrl,            // Mode, clock select, capture setup
   input wire cpu_req_s cpu,                // Byte access request from the CPU
   output logic [7:0] cpu_rdata,            // Read data, valid cycle after rd
   input wire logic [NFLAG-1:0] flag_clear, // Write-one-to-clear pulses
   input wire logic [NFLAG-1:0] flag_mask,  // Per-request interrupt enables
   output logic [NFLAG-1:0] timer_flag_reg, // Sticky event flags
   output logic [NFLAG-1:0] irq_req,        // Masked interrupt requests
   input wire logic external_count_pin,     // External tick source
   input wire logic capture_input_pin,      // Capture trigger pin
   input wire logic comparator_output,      // Alternate capture trigger
   output logic [NCMP-1:0] compare_output_pin, // Waveform outputs
   output logic at_bottom,                  // Counter equals zero
   output logic [15:0] count_value          // Live counter
);

   // ---------------------------------------------------------------
   // Tick generation
   // ---------------------------------------------------------------
   logic [PRESC_W-1:0] presc_q, presc_d;
   logic ext_prev_q, ext_prev_d;
   logic tick;
   logic ext_pin;
   logic armed_q, armed_d;

   assign ext_pin = HAS_EXT_PIN ? external_count_pin : 1'b0;

   always_comb begin
      presc_d = power_gate ? presc_q : presc_q + 10'h001;
      ext_prev_d = ext_pin;
      // Edge detectors ignore the first cycle after reset, so an unfiltered pin idling high gives no false edge
      armed_d = 1'b1;
      tick = 1'b0;
      unique case (ctrl.clk_sel)
         CS_NONE: tick = 1'b0;
         CS_DIV1: tick = 1'b1;
         CS_DIV8: tick = (presc_q & PRE_MASK8) == PRE_MASK8;
         CS_DIV64: tick = (presc_q & PRE_MASK64) == PRE_MASK64;
         CS_DIV256: tick = (presc_q & PRE_MASK256) == PRE_MASK256;
         CS_DIV1024: tick = (presc_q & PRE_MASK1024) == PRE_MASK1024;
         CS_EXT_FALL: tick = armed_q && ext_prev_q && !ext_pin;
         CS_EXT_RISE: tick = armed_q && !ext_prev_q && ext_pin;
      endcase
      if (power_gate) begin
         tick = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         presc_q <= '0;
         ext_prev_q <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         presc_q <= presc_d;
         ext_prev_q <= ext_prev_d;
         armed_q <= armed_d;
      end
   end

   // ---------------------------------------------------------------
   // Capture input filter and edge detect
   // ---------------------------------------------------------------
   logic [FILTER_LEN-1:0] filt_q, filt_d;
   logic cap_lvl_q, cap_lvl_d;
   logic cap_raw, cap_event;

   always_comb begin
      cap_raw = ctrl.cap_from_comparator ? comparator_output : capture_input_pin;
      filt_d = {filt_q[FILTER_LEN-2:0], cap_raw};
      cap_lvl_d = cap_lvl_q;
      // Filter trades a few cycles of latency for spike rejection
      if (!ctrl.cap_filter_en) begin
         cap_lvl_d = cap_raw;
      end else if (&filt_q) begin
         cap_lvl_d = 1'b1;
      end else if (~|filt_q) begin
         cap_lvl_d = 1'b0;
      end
      cap_event = armed_q && !power_gate && (cap_lvl_d != cap_lvl_q) &&
                  (cap_lvl_d == ctrl.cap_edge_rise);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         filt_q <= '0;
         cap_lvl_q <= 1'b0;
      end else begin
         filt_q <= filt_d;
         cap_lvl_q <= cap_lvl_d;
      end
   end

   // ---------------------------------------------------------------
   // Counter, compares, capture, holding register, flags
   // ---------------------------------------------------------------
   logic [15:0] count_q, count_d;
   logic [15:0] cmp_buf_q [NCMP], cmp_buf_d [NCMP];
   logic [15:0] cmp_act_q [NCMP], cmp_act_d [NCMP];
   logic [15:0] cap_q, cap_d;
   logic [7:0] hold_q, hold_d;
   logic [7:0] rdata_q, rdata_d;
   logic [NFLAG-1:0] flag_q, flag_d;
   logic [NCMP-1:0] wave_q, wave_d;
   dir_e dir_q, dir_d;
   logic [15:0] top_val;
   logic [NFLAG-1:0] flag_set;
   logic pwm, phase, at_top, lo_wr, lo_rd;
   top_src_e top_src;

   always_comb begin
      top_src = wgm_top(ctrl.wgm);
      pwm = wgm_pwm(ctrl.wgm);
      phase = wgm_phase(ctrl.wgm);
      unique case (top_src)
         TOP_SRC_8: top_val = TOP_8BIT;
         TOP_SRC_9: top_val = TOP_9BIT;
         TOP_SRC_10: top_val = TOP_10BIT;
         TOP_SRC_CMPA: top_val = cmp_act_q[0];
         TOP_SRC_CAP: top_val = cap_q;
         default: top_val = COUNT_MAX;
      endcase
      at_top = (count_q == top_val);
      lo_wr = cpu.wr && !cpu.high;
      lo_rd = cpu.rd && !cpu.high;

      count_d = count_q;
      dir_d = dir_q;
      cap_d = cap_q;
      hold_d = hold_q;
      rdata_d = rdata_q;
      wave_d = wave_q;
      flag_set = '0;
      for (int i = 0; i < NCMP; i++) begin
         cmp_buf_d[i] = cmp_buf_q[i];
         cmp_act_d[i] = cmp_act_q[i];
      end

      // Counting sequence
      if (tick) begin
         if (phase) begin
            if (dir_q == DIR_UP && at_top) begin
               dir_d = DIR_DOWN;
               count_d = count_q - 16'h0001;
            end else if (dir_q == DIR_DOWN && count_q == COUNT_BOTTOM) begin
               dir_d = DIR_UP;
               count_d = count_q + 16'h0001;
               flag_set[FLG_OVF] = 1'b1;
            end else begin
               count_d = (dir_q == DIR_UP) ? count_q + 16'h0001 : count_q - 16'h0001;
            end
         end else begin
            dir_d = DIR_UP;
            count_d = at_top ? COUNT_BOTTOM : count_q + 16'h0001;
            if ((pwm && at_top) || count_q == COUNT_MAX) begin
               flag_set[FLG_OVF] = 1'b1;
            end
         end
         // Buffered compares load at top in PWM modes, immediately otherwise
         if (pwm && at_top) begin
            for (int i = 0; i < NCMP; i++) begin
               cmp_act_d[i] = cmp_buf_q[i];
            end
         end
         for (int i = 0; i < NCMP; i++) begin
            if (count_q == cmp_act_q[i]) begin
               flag_set[FLG_CMP0 + i] = 1'b1;
               if (!pwm) begin
                  wave_d[i] = !wave_q[i];
               end
            end
         end
      end
      if (!pwm) begin
         for (int i = 0; i < NCMP; i++) begin
            cmp_act_d[i] = cmp_buf_q[i];
         end
      end
      if (pwm) begin
         for (int i = 0; i < NCMP; i++) begin
            wave_d[i] = (count_d < cmp_act_d[i]);
         end
         if (top_src == TOP_SRC_CMPA) begin
            wave_d[0] = 1'b0;
         end
      end

      // Capture: copy and flag in the same cycle
      if (cap_event && top_src != TOP_SRC_CAP) begin
         cap_d = count_q;
         flag_set[FLG_CAP] = 1'b1;
      end

      // CPU byte access through the shared holding register
      if (cpu.wr && cpu.high) begin
         hold_d = cpu.data;
      end
      if (lo_wr) begin
         unique case (cpu.sel)
            REG_COUNT: count_d = {hold_q, cpu.data};
            REG_CMP_A: cmp_buf_d[0] = {hold_q, cpu.data};
            REG_CMP_B: cmp_buf_d[1] = {hold_q, cpu.data};
            REG_CMP_C: cmp_buf_d[2] = {hold_q, cpu.data};
            REG_CAPTURE: begin
               if (top_src == TOP_SRC_CAP) begin
                  cap_d = {hold_q, cpu.data};
               end
            end
            default: ;
         endcase
      end
      if (cpu.rd) begin
         unique case (cpu.sel)
            REG_COUNT: rdata_d = cpu.high ? hold_q : count_q[7:0];
            REG_CMP_A: rdata_d = cpu.high ? cmp_buf_q[0][15:8] : cmp_buf_q[0][7:0];
            REG_CMP_B: rdata_d = cpu.high ? cmp_buf_q[1][15:8] : cmp_buf_q[1][7:0];
            REG_CMP_C: rdata_d = cpu.high ? cmp_buf_q[2][15:8] : cmp_buf_q[2][7:0];
            REG_CAPTURE: rdata_d = cpu.high ? hold_q : cap_q[7:0];
            default: rdata_d = BYTE_RESET;
         endcase
      end
      if (lo_rd && cpu.sel == REG_COUNT) begin
         hold_d = count_q[15:8];
      end
      if (lo_rd && cpu.sel == REG_CAPTURE) begin
         hold_d = cap_q[15:8];
      end

      // Set wins over a clear in the same cycle
      flag_d = (flag_q & ~flag_clear) | flag_set;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_q <= REG_RESET;
         cap_q <= REG_RESET;
         hold_q <= BYTE_RESET;
         rdata_q <= BYTE_RESET;
         flag_q <= '0;
         wave_q <= '0;
         dir_q <= DIR_UP;
         for (int i = 0; i < NCMP; i++) begin
            cmp_buf_q[i] <= REG_RESET;
            cmp_act_q[i] <= REG_RESET;
         end
      end else begin
         count_q <= count_d;
         cap_q <= cap_d;
         hold_q <= hold_d;
         rdata_q <= rdata_d;
         flag_q <= flag_d;
         wave_q <= wave_d;
         dir_q <= dir_d;
         for (int i = 0; i < NCMP; i++) begin
            cmp_buf_q[i] <= cmp_buf_d[i];
            cmp_act_q[i] <= cmp_act_d[i];
         end
      end
   end

   assign cpu_rdata = rdata_q;
   assign timer_flag_reg = flag_q;
   assign irq_req = flag_q & flag_mask;
   assign compare_output_pin = wave_q;
   assign at_bottom = (count_q == COUNT_BOTTOM);
   assign count_value = count_q;

endmodule

// >>> common/timer16_pkg.sv
// Constants, types and mode decoding for the 16-bit timer core.
package timer16_pkg;

   localparam int NCMP = 3;
   localparam int NFLAG = 5;
   localparam int PRESC_W = 10;
   localparam int FILTER_LEN = 4;

   localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] TOP_8BIT = 16'h00ff;
   localparam logic [15:0] TOP_9BIT = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Flag and mask bit positions
   localparam int FLG_OVF = 0;
   localparam int FLG_CMP0 = 1;
   localparam int FLG_CAP = 4;

   // Clock select codes
   localparam logic [2:0] CS_NONE = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // Prescaler terminal masks: a tick fires when the masked bits are all ones
   localparam logic [PRESC_W-1:0] PRE_MASK8 = 10'h007;
   localparam logic [PRESC_W-1:0] PRE_MASK64 = 10'h03f;
   localparam logic [PRESC_W-1:0] PRE_MASK256 = 10'h0ff;
   localparam logic [PRESC_W-1:0] PRE_MASK1024 = 10'h3ff;

   typedef enum logic [2:0] {
      REG_COUNT = 3'h0,
      REG_CMP_A = 3'h1,
      REG_CMP_B = 3'h2,
      REG_CMP_C = 3'h3,
      REG_CAPTURE = 3'h4
   } reg_sel_e;

   typedef enum logic [2:0] {
      TOP_SRC_MAX, TOP_SRC_8, TOP_SRC_9, TOP_SRC_10, TOP_SRC_CMPA, TOP_SRC_CAP
   } top_src_e;

   typedef enum logic [1:0] {
      DIR_UP = 2'b01,
      DIR_DOWN = 2'b10
   } dir_e;

   typedef struct packed {
      logic wr;
      logic rd;
      reg_sel_e sel;
      logic high;
      logic [7:0] data;
   } cpu_req_s;

   typedef struct packed {
      logic [3:0] wgm;
      logic [2:0] clk_sel;
      logic cap_edge_rise;
      logic cap_filter_en;
      logic cap_from_comparator;
   } timer_ctrl_s;

   function automatic top_src_e wgm_top(input logic [3:0] wgm);
      unique case (wgm)
         4'h1, 4'h5: wgm_top = TOP_SRC_8;
         4'h2, 4'h6: wgm_top = TOP_SRC_9;
         4'h3, 4'h7: wgm_top = TOP_SRC_10;
         4'h4, 4'h9, 4'hb, 4'hf: wgm_top = TOP_SRC_CMPA;
         4'h8, 4'ha, 4'hc, 4'he: wgm_top = TOP_SRC_CAP;
         default: wgm_top = TOP_SRC_MAX;
      endcase
   endfunction

   function automatic logic wgm_pwm(input logic [3:0] wgm);
      wgm_pwm = !(wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hc || wgm == 4'hd);
   endfunction

   function automatic logic wgm_phase(input logic [3:0] wgm);
      wgm_phase = (wgm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
   endfunction

endpackage

// >>> tb/timer16_monitor.sv
// Port-level assertions for the timer core.
`timescale 1ns/1ns
module timer16_monitor import timer16_pkg::*; (
   input wire logic clock, // Clock
   input wire logic rst, // Reset
   input wire logic power_gate, // Gate
   input wire timer_ctrl_s ctrl, // Setup
   input wire cpu_req_s cpu, // Request
   input wire logic [7:0] cpu_rdata, // Read byte
   input wire logic [NFLAG-1:0] flag_clear, // Clears
   input wire logic [NFLAG-1:0] flag_mask, // Masks
   input wire logic [NFLAG-1:0] timer_flag_reg, // Flags
   input wire logic [NFLAG-1:0] irq_req, // Requests
   input wire logic capture_input_pin, // Capture pin
   input wire logic at_bottom, // Bottom
   input wire logic [15:0] count_value // Counter
);
   // ------------------------------
   // History of counter and data
   // ------------------------------
   logic [15:0] cnt1_q, cnt2_q, cnt3_q;
   logic [7:0] dat1_q, dat2_q;
   always_ff @(posedge clock) begin
      cnt1_q <= count_value;
      cnt2_q <= cnt1_q;
      cnt3_q <= cnt2_q;
      dat1_q <= cpu.data;
      dat2_q <= dat1_q;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence hi_wr_s; cpu.wr && !cpu.rd && cpu.high; endsequence
   sequence lo_wr_s; cpu.wr && cpu.sel == REG_COUNT && !cpu.high; endsequence
   sequence lo_rd_s; cpu.rd && !cpu.wr && cpu.sel == REG_COUNT && !cpu.high; endsequence
   sequence hi_rd_s; cpu.rd && !cpu.wr && cpu.sel == REG_COUNT && cpu.high; endsequence
   sequence cmp_rd_s; cpu.rd && !cpu.wr && cpu.sel inside {REG_CMP_A, REG_CMP_B, REG_CMP_C};
   endsequence
   bottom_flag_a: assert property (at_bottom == (count_value == COUNT_BOTTOM))
      else $error("bottom flag wrong");
   irq_mask_a: assert property (irq_req == (timer_flag_reg & flag_mask))
      else $error("masked request wrong");
   pair_write_a: assert property (hi_wr_s ##1 lo_wr_s |=> count_value == {dat2_q, dat1_q})
      else $error("paired write wrong");
   low_read_a: assert property (lo_rd_s |=> cpu_rdata == cnt1_q[7:0])
      else $error("low byte read wrong");
   pair_read_a: assert property (lo_rd_s ##1 hi_rd_s |=> cpu_rdata == cnt2_q[15:8])
      else $error("held high byte wrong");
   direct_cmp_a: assert property (lo_rd_s ##1 cmp_rd_s ##1 hi_rd_s |=>
      cpu_rdata == cnt3_q[15:8]) else $error("compare read disturbed holding");
   stop_freeze_a: assert property ((ctrl.clk_sel == CS_NONE || power_gate) && !cpu.wr |=>
      $stable(count_value)) else $error("counter moved while stopped");
   tick_count_a: assert property (ctrl.clk_sel == CS_DIV1 && !power_gate && !cpu.wr &&
      ctrl.wgm == 4'h0 |=> count_value == cnt1_q + 16'h1) else $error("counter did not step");
   max_wrap_a: assert property (ctrl.clk_sel == CS_DIV1 && !power_gate && !cpu.wr &&
      ctrl.wgm == 4'h0 && count_value == COUNT_MAX |=> timer_flag_reg[FLG_OVF] &&
      count_value == COUNT_BOTTOM) else $error("no wrap at maximum");
   capture_set_a: assert property (ctrl.wgm == 4'h0 && !ctrl.cap_filter_en &&
      ctrl.cap_edge_rise && !ctrl.cap_from_comparator && !power_gate &&
      $rose(capture_input_pin) |-> ##[1:2] timer_flag_reg[FLG_CAP]) else $error("no capture");
   ovf_clear_a: assert property (ctrl.clk_sel == CS_NONE && flag_clear[FLG_OVF] |=>
      !timer_flag_reg[FLG_OVF]) else $error("flag not cleared");
endmodule
bind timer16_core timer16_monitor i_timer16_monitor (.clock(clock), .rst(rst),
   .power_gate(power_gate), .ctrl(ctrl), .cpu(cpu), .cpu_rdata(cpu_rdata),
   .flag_clear(flag_clear), .flag_mask(flag_mask), .timer_flag_reg(timer_flag_reg),
   .irq_req(irq_req), .capture_input_pin(capture_input_pin), .at_bottom(at_bottom),
   .count_value(count_value));

// >>> tb/cpu_model.sv
// CPU side model issuing byte accesses to the timer core.
`timescale 1ns/1ns
module cpu_model import timer16_pkg::*; (
   input wire logic clock, // Clock
   input wire logic [7:0] cpu_rdata, // Read byte
   output cpu_req_s cpu // Request
);
   // ------------------------------
   // Bus cycles
   // ------------------------------
   logic [7:0] junk_q = 8'h5a;
   initial cpu = '0;
   // Returns the byte answered to the previous cycle
   task automatic step(input logic w, input logic r, input reg_sel_e s, input logic h,
      input logic [7:0] d, output logic [7:0] q);
      @(negedge clock);
      q = cpu_rdata;
      cpu = '{w, r, s, h, d};
   endtask
   // Idle data toggles so a stale byte is never mistaken for a write
   task automatic idle(output logic [7:0] q);
      junk_q = ~junk_q;
      step(1'b0, 1'b0, REG_COUNT, 1'b0, junk_q, q);
   endtask
   // No interrupt handler shares the holding byte, so pairs are never split
   task automatic write16(input reg_sel_e s, input logic [15:0] v);
      logic [7:0] q;
      step(1'b1, 1'b0, s, 1'b1, v[15:8], q);
      step(1'b1, 1'b0, s, 1'b0, v[7:0], q);
      idle(q);
   endtask
   task automatic read16(input reg_sel_e s, output logic [15:0] v);
      logic [7:0] q;
      step(1'b0, 1'b1, s, 1'b0, junk_q, q);
      step(1'b0, 1'b1, s, 1'b1, junk_q, v[7:0]);
      idle(v[15:8]);
   endtask
endmodule

// >>> tb/tb_timer16_core.sv
// Self-checking bench for the timer core.
`timescale 1ns/1ns
module tb_timer16_core import timer16_pkg::*;;
   // ------------------------------
   // Signals and model state
   // ------------------------------
   logic clock = 1'b0, rst = 1'b1, power_gate = 1'b1, ext_pin = 1'b0, cap_pin = 1'b0;
   logic cmp_out = 1'b0;
   timer_ctrl_s ctrl = '0;
   cpu_req_s cpu;
   logic [7:0] cpu_rdata, q;
   logic [NFLAG-1:0] flag_clear = '0, flag_mask = '0, timer_flag_reg, irq_req;
   logic [NCMP-1:0] cmp_pins;
   logic at_bottom;
   logic [15:0] count_value, count_second, got;
   int fail_count = 0, check_count = 0, seed = 32'h4fd9, m_count, k;
   int m_cmp[$];
   always #2 clock = ~clock;
   timer16_core #(.HAS_EXT_PIN(1'b1)) i_timer16_core (.clock(clock), .rst(rst),
      .power_gate(power_gate), .ctrl(ctrl), .cpu(cpu), .cpu_rdata(cpu_rdata),
      .flag_clear(flag_clear), .flag_mask(flag_mask), .timer_flag_reg(timer_flag_reg),
      .irq_req(irq_req), .external_count_pin(ext_pin), .capture_input_pin(cap_pin),
      .comparator_output(cmp_out), .compare_output_pin(cmp_pins), .at_bottom(at_bottom),
      .count_value(count_value));
   // Second instance: no external count pin, otherwise fed alike
   timer16_core #(.HAS_EXT_PIN(1'b0)) i_timer16_core_second (.clock(clock), .rst(rst),
      .power_gate(power_gate), .ctrl(ctrl), .cpu(cpu), .cpu_rdata(),
      .flag_clear(flag_clear), .flag_mask(flag_mask), .timer_flag_reg(), .irq_req(),
      .external_count_pin(ext_pin), .capture_input_pin(cap_pin), .comparator_output(cmp_out),
      .compare_output_pin(), .at_bottom(), .count_value(count_second));
   cpu_model i_cpu_model (.clock(clock), .cpu_rdata(cpu_rdata), .cpu(cpu));
   task automatic check(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic run(input logic [2:0] cs, input int n);
      @(negedge clock);
      ctrl.clk_sel = cs;
      repeat (n) @(negedge clock);
      ctrl.clk_sel = CS_NONE;
   endtask
   task automatic clear_flags;
      @(negedge clock);
      flag_clear = '1;
      @(negedge clock);
      flag_clear = '0;
   endtask
   task automatic wait_cap;
      for (int i = 0; i < 10 && timer_flag_reg[FLG_CAP] !== 1'b1; i++) @(negedge clock);
      if (timer_flag_reg[FLG_CAP] !== 1'b1) begin
         fail_count++;
         conclude();
      end
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   initial begin
      repeat (4) @(negedge clock);
      rst = 1'b0;
      check(count_value, 16'h0000);
      check(16'(at_bottom), 16'h1);
      check(16'(timer_flag_reg | irq_req), 16'h0);
      check(16'(cmp_pins), 16'h0);
      power_gate = 1'b0;
      m_count = 'h01ff;
      i_cpu_model.write16(REG_COUNT, 16'h01ff);
      check(count_value, m_count[15:0]);
      i_cpu_model.read16(REG_COUNT, got);
      check(got, m_count[15:0]);
      for (k = 0; k < NCMP; k++) begin
         m_cmp.push_back(16'hfff9 + ($unsigned($random(seed)) % 6));
         i_cpu_model.write16(reg_sel_e'(k + 1), m_cmp[k][15:0]);
         i_cpu_model.read16(reg_sel_e'(k + 1), got);
         check(got, m_cmp[k][15:0]);
      end
      // Compare read placed inside a counter read pair
      i_cpu_model.step(1'b0, 1'b1, REG_COUNT, 1'b0, 8'h00, q);
      i_cpu_model.step(1'b0, 1'b1, REG_CMP_B, 1'b1, 8'h00, q);
      i_cpu_model.step(1'b0, 1'b1, REG_COUNT, 1'b1, 8'h00, q);
      check(16'(q), 16'(m_cmp[1][15:8]));
      i_cpu_model.idle(q);
      check(16'(q), 16'h01);
      i_cpu_model.write16(REG_CAPTURE, 16'h4321);
      i_cpu_model.read16(REG_CAPTURE, got);
      check(got, 16'h0000);
      m_count = 'hfff8;
      i_cpu_model.write16(REG_COUNT, 16'hfff8);
      flag_mask = NFLAG'($random(seed));
      clear_flags();
      run(CS_DIV1, 10);
      m_count = (m_count + 10) & 'hffff;
      check(count_value, m_count[15:0]);
      check(16'(timer_flag_reg), 16'h0f);
      check(16'(irq_req), 16'(5'h0f & flag_mask));
      check(16'(cmp_pins), 16'h7);
      clear_flags();
      check(16'(timer_flag_reg), 16'h0);
      power_gate = 1'b1;
      run(CS_DIV1, 5);
      check(count_value, m_count[15:0]);
      power_gate = 1'b0;
      // Rising then falling external edges, four of each
      for (k = 0; k < 2; k++) begin
         ctrl.clk_sel = (k == 0) ? CS_EXT_RISE : CS_EXT_FALL;
         repeat (4) begin
            @(negedge clock) ext_pin = 1'b1;
            repeat (2) @(negedge clock);
            ext_pin = 1'b0;
            @(negedge clock);
         end
         repeat (2) @(negedge clock);
         ctrl.clk_sel = CS_NONE;
         m_count = m_count + 4;
         check(count_value, m_count[15:0]);
      end
      check(count_second, 16'(m_count - 8));
      // Sixteen cycles hold exactly two divide-by-8 ticks, whatever the phase
      run(CS_DIV8, 16);
      m_count = m_count + 2;
      check(count_value, m_count[15:0]);
      ctrl.wgm = 4'h5;
      i_cpu_model.write16(REG_COUNT, 16'h00fe);
      clear_flags();
      run(CS_DIV1, 3);
      check(count_value, 16'h0001);
      check(16'(timer_flag_reg[FLG_OVF]), 16'h1);
      // Compare A as top: new values wait for top, pin A stays low
      ctrl.wgm = 4'hf;
      i_cpu_model.write16(REG_CMP_A, 16'h0005);
      i_cpu_model.write16(REG_CMP_B, 16'h0003);
      i_cpu_model.write16(REG_COUNT, m_cmp[0][15:0]);
      run(CS_DIV1, 4);
      check(count_value, 16'h0003);
      check(16'(cmp_pins), 16'h4);
      ctrl.wgm = 4'he;
      i_cpu_model.write16(REG_CAPTURE, 16'h4321);
      i_cpu_model.read16(REG_CAPTURE, got);
      check(got, 16'h4321);
      ctrl.wgm = 4'h0;
      i_cpu_model.write16(REG_COUNT, 16'h1234);
      clear_flags();
      ctrl.cap_edge_rise = 1'b1;
      @(negedge clock) cap_pin = 1'b1;
      wait_cap();
      i_cpu_model.read16(REG_CAPTURE, got);
      check(got, 16'h1234);
      ctrl.cap_filter_en = 1'b1;
      cap_pin = 1'b0;
      repeat (6) @(negedge clock);
      clear_flags();
      cap_pin = 1'b1;
      repeat (2) @(negedge clock);
      cap_pin = 1'b0;
      repeat (8) @(negedge clock);
      check(16'(timer_flag_reg[FLG_CAP]), 16'h0);
      cap_pin = 1'b1;
      wait_cap();
      ctrl.cap_filter_en = 1'b0;
      ctrl.cap_from_comparator = 1'b1;
      i_cpu_model.write16(REG_COUNT, 16'h5678);
      clear_flags();
      cmp_out = 1'b1;
      wait_cap();
      i_cpu_model.read16(REG_CAPTURE, got);
      check(got, 16'h5678);
      conclude();
   end
endmodule
